/* File: core/gss_consts.svh */
// constants for the gain switch selector
`ifndef GSS_CONSTS_SVH
`define GSS_CONSTS_SVH
`define GSS_SRC_OFF 3'h0
`define GSS_SRC_INPUT 3'h1
`define GSS_SRC_CMD_FREQ 3'h2
`define GSS_SRC_DROOP 3'h3
`define GSS_SRC_SPEED 3'h4
`define GSS_POL_HIGH 1'h0
`define GSS_POL_LOW 1'h1
`define GSS_THRESH_MAX 14'h270F
`define GSS_THRESH_DEF 14'h000A
`define GSS_TC_MAX_MS 7'h64
`define GSS_TC_DEF_MS 7'h01
`define GSS_AUTOTUNE_OFF 2'h3
`define GSS_VIB_MANUAL 2'h2
`define GSS_CLK_HZ 25000000
`define GSS_CYC_PER_MS (`GSS_CLK_HZ / 1000)
`define GSS_MS_CNT_W 15
`define GSS_FRAC_W 16
`define GSS_MIX_MAX 16'hFFFF
`define GSS_ALT_INERTIA_DEF 16'h0046
`define GSS_ALT_INERTIA_MAX 16'h0BB8
`define GSS_ALT_POS_MIN 16'h0001
`define GSS_ALT_POS_MAX 16'h07D0
`define GSS_ALT_SPD_MIN 16'h0014
`define GSS_ALT_SPD_MAX 16'hC350
`define GSS_ALT_INT_MIN 16'h0001
`define GSS_ALT_INT_MAX 16'hC350
`define GSS_ALT_VIB_MIN 16'h0001
`define GSS_ALT_VIB_MAX 16'h03E8
`endif

/* File: core/gss_gain_switch_selector.sv */
// gain scheduling selector: picks and blends normal and alternate gains
`timescale 1ns/1ps
`include "gss_consts.svh"
module gss_gain_switch_selector (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire gss_pkg::gss_config_t cfg,
   input wire gss_pkg::gss_gain_set_t normal_set,
   input wire gss_pkg::gss_gain_set_t alt_set,
   input wire logic gain_switch_input,
   input wire logic [13:0] command_freq,
   input wire logic [13:0] droop_pulses,
   input wire logic [13:0] motor_speed,
   output gss_pkg::gss_gain_set_t active_set,
   output logic alt_active,
   output logic [2:0] latched_source,
   output logic config_error
);
   import gss_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // source latch: sampled once after reset release, stands until next reset
   logic [2:0] src_reg, src_next;
   logic src_taken_reg, src_taken_next;

   always_comb begin
      src_next = src_reg;
      src_taken_next = 1'b1;
      if (!src_taken_reg) begin
         src_next = cfg.switch_source_select;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         src_reg <= `GSS_SRC_OFF;
         src_taken_reg <= 1'b0;
      end else begin
         src_reg <= src_next;
         src_taken_reg <= src_taken_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // condition evaluation
   logic [13:0] thresh;
   logic [13:0] quantity;
   logic use_input;
   logic cond;
   logic [6:0] tc_ms;
   logic range_bad;

   always_comb begin
      // out-of-range settings fall back to defaults rather than saturating
      thresh = cfg.switch_threshold;
      if (cfg.switch_threshold > `GSS_THRESH_MAX) begin
         thresh = `GSS_THRESH_DEF;
      end
      tc_ms = cfg.switch_time_constant;
      if (cfg.switch_time_constant > `GSS_TC_MAX_MS) begin
         tc_ms = `GSS_TC_DEF_MS;
      end
      quantity = 14'h0000;
      use_input = 1'b0;
      if (src_reg == `GSS_SRC_INPUT) begin
         use_input = 1'b1;
      end else if (src_reg == `GSS_SRC_CMD_FREQ) begin
         quantity = command_freq;
      end else if (src_reg == `GSS_SRC_DROOP) begin
         quantity = droop_pulses;
      end else if (src_reg == `GSS_SRC_SPEED) begin
         quantity = motor_speed;
      end
      cond = 1'b0;
      if (src_reg >= `GSS_SRC_INPUT && src_reg <= `GSS_SRC_SPEED) begin
         if (cfg.polarity == `GSS_POL_HIGH) begin
            cond = use_input ? gain_switch_input
                             : (quantity >= thresh);
         end else begin
            cond = use_input ? !gain_switch_input
                             : (quantity <= thresh);
         end
      end
      // a bad alternate set is refused as a whole, never clipped per field
      range_bad = 1'b0;
      if (alt_set.position_gain < `GSS_ALT_POS_MIN ||
          alt_set.position_gain > `GSS_ALT_POS_MAX ||
          alt_set.speed_gain < `GSS_ALT_SPD_MIN ||
          alt_set.speed_gain > `GSS_ALT_SPD_MAX ||
          alt_set.integral_comp < `GSS_ALT_INT_MIN ||
          alt_set.integral_comp > `GSS_ALT_INT_MAX ||
          alt_set.inertia_ratio > `GSS_ALT_INERTIA_MAX ||
          alt_set.vibration_freq < `GSS_ALT_VIB_MIN ||
          alt_set.vibration_freq > `GSS_ALT_VIB_MAX) begin
         range_bad = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // blend timing: one mix step per ms tick (every clock at tc 0); step is room/tc
   logic [`GSS_MS_CNT_W-1:0] ms_cnt_reg, ms_cnt_next;
   logic [`GSS_FRAC_W-1:0] mix_reg, mix_next;
   gss_state_t state_reg, state_next;
   logic ms_tick;
   logic [`GSS_FRAC_W-1:0] step;
   logic [`GSS_FRAC_W-1:0] room;

   always_comb begin
      // free-running ms counter: the first blend step lands anywhere in 1 ms
      ms_tick = (ms_cnt_reg == `GSS_MS_CNT_W'(`GSS_CYC_PER_MS - 1));
      ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
      // first-order: step is a fraction of the remaining distance
      state_next = cond ? GSS_ALTERNATE : GSS_NORMAL;
      room = (state_reg == GSS_ALTERNATE) ? (`GSS_MIX_MAX - mix_reg)
                                          : mix_reg;
      if (tc_ms == 7'h00) begin
         step = room;
      end else begin
         step = `GSS_FRAC_W'(room / tc_ms);
         if (step == '0 && room != '0) begin
            step = `GSS_FRAC_W'(1);
         end
      end
      mix_next = mix_reg;
      case (state_reg)
         GSS_NORMAL: begin
            if (ms_tick || tc_ms == 7'h00) begin
               mix_next = mix_reg - step;
            end
         end
         GSS_ALTERNATE: begin
            if (ms_tick || tc_ms == 7'h00) begin
               mix_next = mix_reg + step;
            end
         end
         default: mix_next = mix_reg;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_cnt_reg <= '0;
         mix_reg <= '0;
         state_reg <= GSS_NORMAL;
      end else begin
         ms_cnt_reg <= ms_cnt_next;
         mix_reg <= mix_next;
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-field blending and enables
   logic [4:0] field_en;
   gss_gain_set_t target_set;
   gss_gain_set_t out_next;
   gss_gain_set_t out_reg;
   logic alt_next, alt_reg;
   logic err_next, err_reg;

   always_comb begin
      // the first four fields follow auto-tuning; vibration its own mode, with the input source only
      field_en[4:1] = {4{cfg.auto_tuning_setting == `GSS_AUTOTUNE_OFF}};
      // stopping the motor before a vibration swap is left to the loop side
      field_en[0] = (cfg.vibration_tuning_setting == `GSS_VIB_MANUAL) &&
                    (src_reg == `GSS_SRC_INPUT);
      target_set = alt_set;
      alt_next = (state_reg == GSS_ALTERNATE);
      err_next = range_bad;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_field
         logic [15:0] nrm;
         logic [15:0] alt;
         logic [32:0] prod;
         assign nrm = normal_set[gi*16 +: 16];
         assign alt = target_set[gi*16 +: 16];
         // nrm + (alt - nrm) * mix, signed difference kept in 17 bits
         assign prod = 33'($signed({1'b0, alt}) - $signed({1'b0, nrm}))
                       * 33'(mix_reg);
         // full scale is one short of unity, so a rising blend would stop
         // one below the target; at full scale the target is taken as is
         assign out_next[gi*16 +: 16] = (!field_en[gi] || range_bad) ? nrm :
            (mix_reg == `GSS_MIX_MAX) ? alt :
            16'(nrm + 16'(prod[31:16]));
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_reg <= '0;
         alt_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
         alt_reg <= alt_next;
         err_reg <= err_next;
      end
   end

   assign active_set = out_reg;
   assign alt_active = alt_reg;
   assign latched_source = src_reg;
   assign config_error = err_reg;
endmodule

/* File: core/gss_pkg.sv */
// types for the gain switch selector
package gss_pkg;
   typedef struct packed {
      logic [15:0] inertia_ratio;
      logic [15:0] position_gain;
      logic [15:0] speed_gain;
      logic [15:0] integral_comp;
      logic [15:0] vibration_freq;
   } gss_gain_set_t;
   typedef struct packed {
      logic [2:0] switch_source_select;
      logic polarity;
      logic [13:0] switch_threshold;
      logic [6:0] switch_time_constant;
      logic [1:0] auto_tuning_setting;
      logic [1:0] vibration_tuning_setting;
   } gss_config_t;
   typedef enum logic [0:0] {GSS_NORMAL, GSS_ALTERNATE} gss_state_t;
endpackage

/* File: tb/gss_gain_switch_selector_monitor.sv */
// checker bound to the gain switch selector
`timescale 1ns/1ps
module gss_gain_switch_selector_monitor (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire gss_pkg::gss_config_t cfg,
   input wire gss_pkg::gss_gain_set_t normal_set,
   input wire logic gain_switch_input,
   input wire logic [13:0] command_freq,
   input wire logic [13:0] motor_speed,
   input wire gss_pkg::gss_gain_set_t active_set,
   input wire logic alt_active,
   input wire logic [2:0] latched_source
);
   import gss_pkg::*;
   wire [2:0] src = latched_source;
   wire pol = cfg.polarity;
   wire [13:0] thr = cfg.switch_threshold;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_in_on;
      (src == 3'h1 && !pol && gain_switch_input)[*3];
   endsequence
   sequence s_in_off;
      (src == 3'h1 && pol && !gain_switch_input)[*3];
   endsequence
   property p_hold; $past(reset_n, 2) |-> $stable(src); endproperty
   a_hold: assert property (p_hold) else $error("source moved");
   property p_off; (src == 3'h0)[*3] |-> !alt_active; endproperty
   a_off: assert property (p_off) else $error("off switched");
   property p_in_on; s_in_on |-> alt_active; endproperty
   a_in_on: assert property (p_in_on) else $error("input on");
   property p_in_off; s_in_off |-> alt_active; endproperty
   a_in_off: assert property (p_in_off) else $error("input off");
   property p_spd;
      (src == 3'h4 && !pol && motor_speed >= thr)[*3] |-> alt_active;
   endproperty
   a_spd: assert property (p_spd) else $error("speed high");
   property p_cmd;
      (src == 3'h2 && pol && command_freq > thr)[*3] |-> !alt_active;
   endproperty
   a_cmd: assert property (p_cmd) else $error("freq above");
   property p_auto; (cfg.auto_tuning_setting != 2'h3)[*3]
      |-> active_set.speed_gain == normal_set.speed_gain; endproperty
   a_auto: assert property (p_auto) else $error("auto gate");
   property p_vib;
      (!(cfg.vibration_tuning_setting == 2'h2 && src == 3'h1))[*3]
      |-> active_set.vibration_freq == normal_set.vibration_freq;
   endproperty
   a_vib: assert property (p_vib) else $error("vib gate");
endmodule
bind gss_gain_switch_selector gss_gain_switch_selector_monitor mon_inst (
   .ref_clk, .reset_n, .cfg, .normal_set, .gain_switch_input,
   .command_freq, .motor_speed, .active_set, .alt_active, .latched_source);

/* File: tb/gss_servo_model.sv */
// far side: loop quantities and the gain switch device
`timescale 1ns/1ps
module gss_servo_model (
   input wire logic ref_clk,
   input wire logic sw_req,
   input wire logic [13:0] qty_req,
   output logic gain_switch_input,
   output logic [13:0] command_freq,
   output logic [13:0] droop_pulses,
   output logic [13:0] motor_speed
);
   assign command_freq = motor_speed;
   assign droop_pulses = motor_speed;
   // rising-edge nonblocking update: never races the bench's falling-edge
   // writes, and the design samples the old value at the same edge
   always @(posedge ref_clk) begin
      motor_speed <= qty_req;
      // switch is only toggled with the motor at a standstill
      if (motor_speed == 14'h0000) begin
         gain_switch_input <= sw_req;
      end
   end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the gain switch selector
`timescale 1ns/1ps
module tb;
   import gss_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic sw_req = 1'b0;
   logic [13:0] qty_req = 14'h0000;
   gss_config_t cfg;
   gss_gain_set_t normal_set, alt_set, active_set;
   logic gain_switch_input, alt_active, config_error;
   logic [13:0] command_freq, droop_pulses, motor_speed;
   logic [2:0] latched_source;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   gss_gain_switch_selector gss_gain_switch_selector_inst (.ref_clk,
      .reset_n, .cfg, .normal_set, .alt_set, .gain_switch_input,
      .command_freq, .droop_pulses, .motor_speed, .active_set,
      .alt_active, .latched_source, .config_error);
   gss_servo_model gss_servo_model_inst (.ref_clk, .sw_req, .qty_req,
      .gain_switch_input, .command_freq, .droop_pulses, .motor_speed);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic restart(input logic [2:0] src);
      reset_n = 1'b0;
      cfg.switch_source_select = src;
      tick(8);
      reset_n = 1'b1;
      tick(3);
      chk({13'h0, latched_source}, {13'h0, src});
   endtask
   // speed is parked at zero first so the switch device may move
   task automatic step(input logic pol, input logic [13:0] q,
                       input logic sw, input logic exp);
      cfg.polarity = pol;
      qty_req = 14'h0000;
      tick(3);
      sw_req = sw;
      tick(3);
      qty_req = q;
      tick(5);
      chk({15'h0, alt_active}, {15'h0, exp});
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 95000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      cfg = '{3'h0, 1'h0, 14'h000A, 7'h00, 2'h3, 2'h2};
      normal_set = '{16'h0032, 16'h0025, 16'h0337, 16'h0151, 16'h03E8};
      alt_set = '{16'h0046, 16'h0050, 16'h0400, 16'h0100, 16'h0200};
      for (int s = 0; s < 5; s++) begin
         restart(s[2:0]);
         step(1'b0, 14'h000A, 1'b1, s != 0);
         step(1'b0, 14'h0009, 1'b0, 1'b0);
         step(1'b1, 14'h000B, 1'b1, 1'b0);
         step(1'b1, 14'h000A, 1'b0, s != 0);
      end
      cfg.switch_threshold = 14'h3FFF;
      step(1'b0, 14'h000A, 1'b0, 1'b1);
      cfg.switch_threshold = 14'h000A;
      cfg.switch_source_select = 3'h1;
      step(1'b0, 14'h000A, 1'b0, 1'b1);
      qty_req = 14'h0000;
      cfg.auto_tuning_setting = 2'h0;
      restart(3'h1);
      sw_req = 1'b1;
      // one ms tick is 25000 cycles; a zero time constant settles in one clock
      tick(25010);
      chk(active_set.position_gain, normal_set.position_gain);
      chk(active_set.vibration_freq, alt_set.vibration_freq);
      cfg.auto_tuning_setting = 2'h3;
      tick(25010);
      for (int i = 0; i < 5; i++) begin
         chk(active_set[16*i+:16], alt_set[16*i+:16]);
      end
      cfg.switch_time_constant = 7'h64;
      sw_req = 1'b0;
      tick(25010);
      chk({15'h0, active_set.speed_gain < alt_set.speed_gain &&
         active_set.speed_gain > normal_set.speed_gain}, 16'h0001);
      chk({15'h0, config_error}, 16'h0000);
      // out-of-range alternate values: refused, normal set shown
      alt_set.speed_gain = 16'h0013;
      tick(3);
      chk({15'h0, config_error}, 16'h0001);
      chk(active_set.speed_gain, normal_set.speed_gain);
      alt_set.speed_gain = 16'h0400;
      alt_set.inertia_ratio = 16'h0BB9;
      tick(3);
      chk({15'h0, config_error}, 16'h0001);
      chk(active_set.inertia_ratio, normal_set.inertia_ratio);
      print_verdict();
   end
endmodule
